// File: tabs_cause.sv
// Transmit abort cause register, clear-on-read logic and abort interrupt
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "tabs_defines.svh"

// Behaviour
// - Cause register holds 14 flag bits naming why transmit abort fired.
// - Reading either clear register clears all flags, the start byte flag included.
// - Clearing start byte flag with cause present drops it one cycle, then sets it again.
// - Slave read request answered with a write command sets bit 15.
// - Slave losing the bus sets bit 14 and bit 12 together.
// - While transmitting, data line mismatch at clock rise means bus is lost.
// - Read command with stale transmit data sets bit 13 and flushes transmit data.
// - Master arbitration loss sets bit 12; with bit 14 it means slave loss.
// - Master operation with master mode disabled sets bit 11.
// - Ten-bit read with restarts disabled sets bit 10.
// - Start byte attempt with restarts disabled sets bit 9.
// - Acknowledged start byte sets bit 7.
// - Every recorded abort flushes the receive data.
module tabs_cause (
    // Clock and reset
    input logic mclk_i,
    input logic nrst_i,
    // Register port
    input logic [7:0] reg_addr_i,
    input logic [31:0] reg_wdata_i,
    input logic reg_wr_i,
    input logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Abort events from the controller
    input tabs_pkg::tabs_evt_t evt_i,
    // Slave transmitter bit and bus pins
    input logic slv_tx_active_i,
    input logic slv_tx_bit_i,
    input logic bus_clock_pin_i,
    input logic bus_data_pin_i,
    // Results
    output logic transmit_abort_interrupt_o,
    output logic slave_lost_bus_o,
    output logic rx_flush_o,
    output logic tx_flush_o,
    output logic master_enable_o,
    output logic restart_enable_o,
    output logic irq_o
);
    tabs_pkg::tabs_state_t st_r;
    tabs_pkg::tabs_state_t st_nxt;
    tabs_pkg::tabs_bus_t bus;
    logic [1:0] pins_sync;
    logic lost_pulse;
    logic [15:0] set_v;
    logic clr_rd;
    logic sb_cause;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    tabs_sync u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .pin_i({bus_clock_pin_i, bus_data_pin_i}),
        .sync_o(pins_sync)
    );

    tabs_arb_mon u_mon (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .scl_i(pins_sync[1]),
        .sda_i(pins_sync[0]),
        .tx_active_i(slv_tx_active_i),
        .tx_bit_i(slv_tx_bit_i),
        .lost_o(lost_pulse)
    );

    // Start byte configuration: extended select and start byte chosen, no restart
    assign sb_cause = !st_r.ctrl[`TABS_CTRL_RESTART_EN] && st_r.target[`TABS_TAR_EXT_SEL]
        && st_r.target[`TABS_TAR_GENERAL_CALL_VS_START_BYTE];

    assign clr_rd = bus.rd && (hit(bus.addr, `TABS_OFS_CLR_ALL)
        || hit(bus.addr, `TABS_OFS_CLR_ABRT));

    always_comb begin
        set_v = 16'h0000;
        set_v[5:0] = evt_i.addr_nack;
        set_v[`TABS_B_SLV_RD_WR_QUEUED] = evt_i.slv_data_req && !evt_i.data_cmd_rd;
        set_v[`TABS_B_SLV_LOST_BUS] = lost_pulse;
        set_v[`TABS_B_SLV_STALE_FLUSH] = evt_i.slv_rd_cmd && evt_i.txfifo_nonempty;
        set_v[`TABS_B_ARBITRATION_LOST_FLAG] = evt_i.mst_arbitration_lost_flag || lost_pulse;
        set_v[`TABS_B_MST_DISABLED] = evt_i.mst_op
            && !st_r.ctrl[`TABS_CTRL_MST_EN];
        set_v[`TABS_B_TENBIT_RD_NORST] = evt_i.mst_tenbit_rd
            && !st_r.ctrl[`TABS_CTRL_RESTART_EN];
        set_v[`TABS_B_SBYTE_NORST] = evt_i.mst_sbyte
            && !st_r.ctrl[`TABS_CTRL_RESTART_EN];
        set_v[`TABS_B_SBYTE_ACKED] = evt_i.sbyte_acked;
        set_v = set_v & `TABS_CAUSE_VALID;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 32'h0000_0000;
        st_nxt.rx_flush = |set_v;
        st_nxt.tx_flush = set_v[`TABS_B_SLV_STALE_FLUSH];
        st_nxt.sb_reassert = 1'b0;
        // Set wins over a clear in the same cycle
        if (clr_rd) begin
            st_nxt.cause = (st_r.cause & 16'h0200) | set_v;
            st_nxt.cause[`TABS_B_SBYTE_NORST] = set_v[`TABS_B_SBYTE_NORST];
            st_nxt.sb_reassert = st_r.cause[`TABS_B_SBYTE_NORST] && sb_cause;
        end else begin
            st_nxt.cause = st_r.cause | set_v;
        end
        if (st_r.sb_reassert) begin
            st_nxt.cause[`TABS_B_SBYTE_NORST] = 1'b1;
        end
        st_nxt.irq_st = st_r.irq_st || (|set_v);
        if (bus.wr) begin
            if (hit(bus.addr, `TABS_OFS_CTRL)) begin
                st_nxt.ctrl = bus.wdata[6:0];
            end
            if (hit(bus.addr, `TABS_OFS_TARGET)) begin
                st_nxt.target = bus.wdata[11:0];
            end
            if (hit(bus.addr, `TABS_OFS_IRQ_ST) && bus.wdata[0] && !(|set_v)) begin
                st_nxt.irq_st = 1'b0;
            end
            if (hit(bus.addr, `TABS_OFS_IRQ_MASK)) begin
                st_nxt.irq_mask = bus.wdata[0];
            end
        end
        if (bus.rd) begin
            unique case (bus.addr)
                `TABS_OFS_CTRL: st_nxt.rdata = {25'h0, st_r.ctrl};
                `TABS_OFS_TARGET: st_nxt.rdata = {20'h0, st_r.target};
                `TABS_OFS_CAUSE: st_nxt.rdata = {16'h0, st_r.cause & `TABS_CAUSE_VALID};
                `TABS_OFS_CLR_ALL: st_nxt.rdata = {31'h0, |st_r.cause};
                `TABS_OFS_CLR_ABRT: st_nxt.rdata = {31'h0, |st_r.cause};
                `TABS_OFS_IRQ_ST: st_nxt.rdata = {31'h0, st_r.irq_st};
                `TABS_OFS_IRQ_MASK: st_nxt.rdata = {31'h0, st_r.irq_mask};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '{ctrl: `TABS_CTRL_RST, target: `TABS_TARGET_RST,
                cause: `TABS_CAUSE_RST, sb_reassert: 1'b0, irq_st: 1'b0,
                irq_mask: `TABS_IRQ_MASK_RST, rdata: 32'h0000_0000,
                rx_flush: 1'b0, tx_flush: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rdata;
    assign transmit_abort_interrupt_o = |st_r.cause;
    assign slave_lost_bus_o = st_r.cause[`TABS_B_SLV_LOST_BUS];
    assign rx_flush_o = st_r.rx_flush;
    assign tx_flush_o = st_r.tx_flush;
    assign master_enable_o = st_r.ctrl[`TABS_CTRL_MST_EN];
    assign restart_enable_o = st_r.ctrl[`TABS_CTRL_RESTART_EN];
    assign irq_o = st_r.irq_st && st_r.irq_mask;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence sb_clear_s;
        clr_rd && st_r.cause[9] && sb_cause && !set_v[9];
    endsequence

    sequence sb_drop_back_s;
        !st_r.cause[9] ##1 st_r.cause[9];
    endsequence

    rsvd_read_zero_a: assert property (
        (bus.rd && bus.addr == 8'h80) |=> (reg_rdata_o[31:16] == 16'h0
        && reg_rdata_o[8] == 1'b0 && reg_rdata_o[6] == 1'b0))
        else $error("Reserved cause bits read nonzero");

    clear_read_a: assert property (
        (clr_rd && set_v == 16'h0) |=> ((st_r.cause & 16'hfdff) == 16'h0))
        else $error("Clear read left cause flags set");

    sbyte_hold_a: assert property (
        sb_clear_s |=> sb_drop_back_s)
        else $error("Start byte flag not dropped for exactly one cycle");

    slv_wr_cmd_a: assert property (
        (evt_i.slv_data_req && !evt_i.data_cmd_rd) |=> st_r.cause[15])
        else $error("Write command on slave read not recorded");

    lost_pair_a: assert property (
        $rose(st_r.cause[14]) |-> st_r.cause[12])
        else $error("Slave lost bus without arbitration lost");

    stale_flush_a: assert property (
        (evt_i.slv_rd_cmd && evt_i.txfifo_nonempty) |=> (st_r.cause[13] && tx_flush_o))
        else $error("Stale transmit data not flagged and flushed");

    arbitration_lost_flag_a: assert property (
        evt_i.mst_arbitration_lost_flag |=> st_r.cause[12])
        else $error("Master arbitration loss not recorded");

    master_dis_a: assert property (
        (evt_i.mst_op && !st_r.ctrl[0]) |=> st_r.cause[11])
        else $error("Master operation while disabled not recorded");

    tenbit_rd_a: assert property (
        (evt_i.mst_tenbit_rd && !st_r.ctrl[5]) |=> st_r.cause[10])
        else $error("Ten-bit read without restart not recorded");

    sbyte_norst_a: assert property (
        (evt_i.mst_sbyte && !st_r.ctrl[5]) |=> st_r.cause[9])
        else $error("Start byte without restart not recorded");

    sbyte_ack_a: assert property (
        evt_i.sbyte_acked |=> st_r.cause[7])
        else $error("Acknowledged start byte not recorded");

    rx_flush_a: assert property (
        (set_v != 16'h0) |=> (rx_flush_o && st_r.cause != 16'h0))
        else $error("Abort did not flush receive data");

    // Refusals and side effects: a flag never sets or clears on its own

    cause_sticky_a: assert property (
        !clr_rd |=> ((st_r.cause & $past(st_r.cause)) == $past(st_r.cause)))
        else $error("Cause flag dropped without a clear read");

    clr_data_a: assert property (
        clr_rd |=> (reg_rdata_o == {31'h0, $past(|st_r.cause)}))
        else $error("Clear read returned wrong any-cause bit");

    sbyte_gone_a: assert property (
        (clr_rd && st_r.cause[9] && !sb_cause && !set_v[9] && !st_r.sb_reassert)
        |=> !st_r.cause[9])
        else $error("Start byte flag kept after its cause was removed");

    slv_rd_cmd_a: assert property (
        (evt_i.slv_data_req && evt_i.data_cmd_rd && !st_r.cause[15]) |=> !st_r.cause[15])
        else $error("Read command on slave request flagged as write");

    lost_both_a: assert property (
        lost_pulse |=> (st_r.cause[14] && st_r.cause[12]))
        else $error("Lost bus did not set both flags");

    lost_active_a: assert property (
        lost_pulse |-> $past(slv_tx_active_i))
        else $error("Lost bus flagged while not transmitting");

    stale_quiet_a: assert property (
        (evt_i.slv_rd_cmd && !evt_i.txfifo_nonempty && !st_r.cause[13]) |=> !st_r.cause[13])
        else $error("Stale data flag set with empty transmit data");

    tx_flush_only_a: assert property (
        !(evt_i.slv_rd_cmd && evt_i.txfifo_nonempty) |=> !tx_flush_o)
        else $error("Transmit flush without stale data");

    stale_irq_a: assert property (
        (evt_i.slv_rd_cmd && evt_i.txfifo_nonempty) |=> transmit_abort_interrupt_o)
        else $error("Stale data did not raise the abort interrupt");

    slv_arb_pair_a: assert property (
        st_r.cause[14] |-> st_r.cause[12])
        else $error("Slave lost flag without arbitration lost flag");

    arb_quiet_a: assert property (
        (!evt_i.mst_arbitration_lost_flag && !lost_pulse && !st_r.cause[12]) |=> !st_r.cause[12])
        else $error("Arbitration lost flag set without a loss");

    master_en_ok_a: assert property (
        (evt_i.mst_op && st_r.ctrl[0] && !st_r.cause[11]) |=> !st_r.cause[11])
        else $error("Master operation flagged while master enabled");

    master_en_wr_a: assert property (
        (bus.wr && bus.addr == 8'h00) |=> (master_enable_o == $past(bus.wdata[0])))
        else $error("Master enable not taken from control write");

    tenbit_rst_a: assert property (
        (evt_i.mst_tenbit_rd && st_r.ctrl[5] && !st_r.cause[10]) |=> !st_r.cause[10])
        else $error("Ten-bit read flagged while restarts enabled");

    restart_wr_a: assert property (
        (bus.wr && bus.addr == 8'h00) |=> (restart_enable_o == $past(bus.wdata[5])))
        else $error("Restart enable not taken from control write");

    sbyte_rst_a: assert property (
        (evt_i.mst_sbyte && st_r.ctrl[5] && !st_r.cause[9] && !st_r.sb_reassert)
        |=> !st_r.cause[9])
        else $error("Start byte flagged while restarts enabled");

    ack_only_a: assert property (
        (!evt_i.sbyte_acked && !st_r.cause[7]) |=> !st_r.cause[7])
        else $error("Start byte acknowledge flag set without an acknowledge");

    rx_flush_only_a: assert property (
        (set_v == 16'h0) |=> !rx_flush_o)
        else $error("Receive flush without an abort event");

    rsvd_flags_zero_a: assert property (
        !st_r.cause[8] && !st_r.cause[6])
        else $error("Reserved cause flag set");
endmodule : tabs_cause

// File: tabs_defines.svh
// Offsets, field positions and reset values of the transmit abort cause block
`ifndef TABS_DEFINES_SVH
`define TABS_DEFINES_SVH

// Register offsets (byte addresses)
`define TABS_OFS_CTRL 8'h00
`define TABS_OFS_TARGET 8'h04
`define TABS_OFS_CLR_ALL 8'h40
`define TABS_OFS_CLR_ABRT 8'h54
`define TABS_OFS_CAUSE 8'h80
`define TABS_OFS_IRQ_ST 8'h84
`define TABS_OFS_IRQ_MASK 8'h88

// Field positions in controller_control and target_address_reg
`define TABS_CTRL_MST_EN 0
`define TABS_CTRL_RESTART_EN 5
`define TABS_TAR_GENERAL_CALL_VS_START_BYTE 10
`define TABS_TAR_EXT_SEL 11

// Field positions in transmit_abort_cause
`define TABS_B_SLV_RD_WR_QUEUED 15
`define TABS_B_SLV_LOST_BUS 14
`define TABS_B_SLV_STALE_FLUSH 13
`define TABS_B_ARBITRATION_LOST_FLAG 12
`define TABS_B_MST_DISABLED 11
`define TABS_B_TENBIT_RD_NORST 10
`define TABS_B_SBYTE_NORST 9
`define TABS_B_SBYTE_ACKED 7

// Reset values and masks
`define TABS_CTRL_RST 7'h21
`define TABS_TARGET_RST 12'h000
`define TABS_CAUSE_RST 16'h0000
`define TABS_CAUSE_VALID 16'hfebf
`define TABS_IRQ_MASK_RST 1'h0

`endif

// File: tabs_pkg.sv
// Types of the transmit abort cause block
package tabs_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tabs_bus_t;

    // Abort events from the controller, one-cycle pulses
    typedef struct packed {
        logic slv_data_req;
        logic data_cmd_rd;
        logic slv_rd_cmd;
        logic txfifo_nonempty;
        logic mst_arbitration_lost_flag;
        logic mst_op;
        logic mst_tenbit_rd;
        logic mst_sbyte;
        logic sbyte_acked;
        logic [5:0] addr_nack;
    } tabs_evt_t;

    typedef struct packed {
        logic [6:0] ctrl;
        logic [11:0] target;
        logic [15:0] cause;
        logic sb_reassert;
        logic irq_st;
        logic irq_mask;
        logic [31:0] rdata;
        logic rx_flush;
        logic tx_flush;
    } tabs_state_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } tabs_sync_t;

    typedef struct packed {
        logic scl_d;
        logic lost;
    } tabs_mon_t;

endpackage : tabs_pkg

// File: tabs_sync.sv
// Two-flop synchroniser for the bus clock and data pins
`timescale 1ns/1ps
module tabs_sync (
    // Clock and reset
    input logic mclk_i,
    input logic nrst_i,
    // Pins and synchronised levels
    input logic [1:0] pin_i,
    output logic [1:0] sync_o
);
    tabs_pkg::tabs_sync_t st_r;
    tabs_pkg::tabs_sync_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_i;
        st_nxt.s2 = st_r.s1;
    end

    // Idle bus lines are high
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '{s1: 2'h3, s2: 2'h3};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_o = st_r.s2;
endmodule : tabs_sync

// File: tabs_arb_mon.sv
// Fail-safe monitor: data line checked against the driven bit at clock rise
`timescale 1ns/1ps
module tabs_arb_mon (
    // Clock and reset
    input logic mclk_i,
    input logic nrst_i,
    // Synchronised bus levels
    input logic scl_i,
    input logic sda_i,
    // Slave transmitter side
    input logic tx_active_i,
    input logic tx_bit_i,
    output logic lost_o
);
    tabs_pkg::tabs_mon_t st_r;
    tabs_pkg::tabs_mon_t st_nxt;
    logic scl_rise;

    assign scl_rise = scl_i && !st_r.scl_d;

    always_comb begin
        st_nxt = st_r;
        st_nxt.scl_d = scl_i;
        st_nxt.lost = scl_rise && tx_active_i && (sda_i != tx_bit_i);
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '{scl_d: 1'h1, lost: 1'h0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lost_o = st_r.lost;

    mismatch_lost_a: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        (scl_rise && tx_active_i && sda_i != tx_bit_i) |=> lost_o)
        else $error("Data mismatch at clock rise did not flag lost bus");
endmodule : tabs_arb_mon

// File: tabs_bus_peer.sv
// Remote bus party that clocks two bits per call, a data bit then a released high line, and can fight the slave
`timescale 1ns/1ps
module tabs_bus_peer (
    // Clock
    input wire logic mclk_i,
    // Wire levels seen at the pins, pulled up when released
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Clock stands still high outside a bit; pull_low breaks the slave's bit
    task automatic bit_cycle(input logic pull_low);
        @(posedge mclk_i);
        scl_o <= 1'b0;
        repeat (4) @(posedge mclk_i);
        sda_o <= ~pull_low;
        repeat (4) @(posedge mclk_i);
        scl_o <= 1'b1;
        repeat (8) @(posedge mclk_i);
        scl_o <= 1'b0;
        repeat (4) @(posedge mclk_i);
        sda_o <= 1'b1;
        repeat (4) @(posedge mclk_i);
        scl_o <= 1'b1;
        repeat (4) @(posedge mclk_i);
    endtask : bit_cycle
endmodule : tabs_bus_peer

// File: tabs_cause_tb.sv
// Self-checking testbench of the transmit abort cause block
`timescale 1ns/1ps
`include "tabs_defines.svh"
module tabs_cause_tb;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] rdata;
    tabs_pkg::tabs_evt_t evt = '0;
    logic stx_act = 1'b0;
    logic stx_bit = 1'b1;
    logic scl;
    logic sda;
    logic abrt_irq, lost, rx_fl, tx_fl, irq;
    logic mst_en;
    logic rst_en;
    logic [31:0] d;
    int err_count = 0;
    int samples_checked = 0;

    always #20 mclk_i = ~mclk_i;

    tabs_cause i_tabs_cause (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
        .evt_i(evt), .slv_tx_active_i(stx_act), .slv_tx_bit_i(stx_bit),
        .bus_clock_pin_i(scl), .bus_data_pin_i(sda), .transmit_abort_interrupt_o(abrt_irq),
        .slave_lost_bus_o(lost), .rx_flush_o(rx_fl), .tx_flush_o(tx_fl),
        .master_enable_o(mst_en), .restart_enable_o(rst_en), .irq_o(irq));

    tabs_bus_peer i_tabs_bus_peer (.mclk_i(mclk_i), .scl_o(scl), .sda_o(sda));

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask : chk1

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge mclk_i);
        wr_s <= 1'b0;
        #1;
    endtask : wr

    // Read data is only valid in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk_i);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask : rd

    task automatic pulse(input tabs_pkg::tabs_evt_t e);
        @(posedge mclk_i);
        evt <= e;
        @(posedge mclk_i);
        evt <= '0;
        #1;
    endtask : pulse

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    initial begin
        #50000;
        err_count++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge mclk_i);
        nrst_i <= 1'b1;
        rd(`TABS_OFS_CAUSE, d); chk32(d, 32'h0);
        rd(`TABS_OFS_CTRL, d); chk32(d, 32'h21);
        chk1(mst_en, 1'b1);
        chk1(rst_en, 1'b1);
        wr(`TABS_OFS_CTRL, 32'h0);
        chk1(mst_en, 1'b0);
        chk1(rst_en, 1'b0);
        pulse('{mst_op:1'b1, default:'0}); chk1(rx_fl, 1'b1);
        rd(`TABS_OFS_IRQ_ST, d); chk32(d, 32'h1);
        chk1(irq, 1'b0);
        wr(`TABS_OFS_IRQ_MASK, 32'h1); chk1(irq, 1'b1);
        wr(`TABS_OFS_IRQ_ST, 32'h1); chk1(irq, 1'b0);
        pulse('{mst_tenbit_rd:1'b1, default:'0});
        pulse('{mst_arbitration_lost_flag:1'b1, default:'0});
        pulse('{sbyte_acked:1'b1, default:'0});
        pulse('{slv_data_req:1'b1, default:'0});
        pulse('{slv_rd_cmd:1'b1, txfifo_nonempty:1'b1, default:'0}); chk1(tx_fl, 1'b1);
        pulse('{addr_nack:6'h3f, default:'0});
        rd(`TABS_OFS_CAUSE, d); chk32(d, 32'hbcbf);
        wr(`TABS_OFS_TARGET, 32'hc00);
        pulse('{mst_sbyte:1'b1, default:'0});
        wr(`TABS_OFS_CAUSE, 32'hffffffff);
        rd(`TABS_OFS_CLR_ABRT, d); chk1(abrt_irq, 1'b0);
        chk32(d, 32'h1);
        @(posedge mclk_i);
        #1 chk1(abrt_irq, 1'b1);
        rd(`TABS_OFS_CAUSE, d); chk32(d, 32'h200);
        wr(`TABS_OFS_CTRL, 32'h20);
        rd(`TABS_OFS_CLR_ALL, d);
        rd(`TABS_OFS_CAUSE, d); chk32(d, 32'h0);
        wr(`TABS_OFS_CTRL, 32'h21);
        pulse('{mst_tenbit_rd:1'b1, default:'0});
        pulse('{mst_sbyte:1'b1, default:'0});
        pulse('{mst_op:1'b1, default:'0});
        pulse('{slv_data_req:1'b1, data_cmd_rd:1'b1, default:'0});
        pulse('{slv_rd_cmd:1'b1, default:'0});
        chk1(tx_fl, 1'b0);
        rd(`TABS_OFS_CAUSE, d); chk32(d, 32'h0);
        rd(8'hfc, d); chk32(d, 32'h0);
        stx_act <= 1'b1;
        i_tabs_bus_peer.bit_cycle(1'b0);
        rd(`TABS_OFS_CAUSE, d); chk32(d, 32'h0);
        i_tabs_bus_peer.bit_cycle(1'b1);
        stx_act <= 1'b0;
        rd(`TABS_OFS_CAUSE, d); chk32(d, 32'h5000);
        chk1(lost, 1'b1);
        test_done();
    end
endmodule : tabs_cause_tb
